/* File: core/rsq_pkg.sv */
/*
 Constants for the system reset sequencer: timing, register map, bit layout.
 Assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package rsq_pkg;
	// Clock and timing figures
	localparam int CLK_PERIOD_NS = 50;
	localparam int PIN_MIN_CYCLES = 4;
	localparam int STOP_FILTER_NS = 12;
	localparam int STOP_FILTER_CYCLES = (STOP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_TIME_US = 1000;
	localparam int XTAL_TIME_US = 4000;
	localparam int POR_CYCLES_DEF = POR_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int XTAL_CYCLES_DEF = XTAL_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int HOLD_CYCLES = 1;
	// Register byte offsets
	localparam logic [7:0] OFS_DBG_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	// Debugger control bit
	localparam int CTRL_RST_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Status and mask layout
	localparam int STAT_W = 5;
	localparam int ST_POR_BIT = 0;
	localparam int ST_WDT_BIT = 1;
	localparam int ST_PIN_BIT = 2;
	localparam int ST_DBG_BIT = 3;
	localparam int ST_WIRQ_BIT = 4;
	localparam logic [STAT_W-1:0] STATUS_RESET = 5'h00;
	localparam logic [STAT_W-1:0] MASK_RESET = 5'h00;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Sequencer states
	typedef enum logic [1:0] {
		RSQ_POR_WAIT,
		RSQ_HOLD,
		RSQ_RUN
	} rsq_state_t;
endpackage

/* File: core/rsq_sync2.sv */
/*
 Two-flop synchroniser for one level.
 Assumes the input may change at any time relative to aclk.
*/
`timescale 1ns/1ps
module rsq_sync2
	import rsq_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;
	logic meta_next;
	logic sync_reg;
	logic sync_next;

	// First stage feeds only the second
	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule

/* File: core/rsq_width_filter.sv */
/*
 Minimum-width filter: output rises on the MIN_CYCLES-th consecutive
 high sample of the input, and falls with the input.
 Assumes a synchronous input.
*/
`timescale 1ns/1ps
module rsq_width_filter
	import rsq_pkg::*;
#(
	parameter int MIN_CYCLES = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic level_in,
	output logic long_enough
);
	localparam int CW = $clog2(MIN_CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(MIN_CYCLES);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;

	initial begin
		if (MIN_CYCLES < 1) $error("MIN_CYCLES must be at least 1");
	end

	// Saturating run length; a short pulse restarts from zero
	always_comb begin
		if (!level_in) cnt_next = '0;
		else if (cnt_reg == LIMIT) cnt_next = cnt_reg;
		else cnt_next = cnt_reg + CW'(1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) cnt_reg <= '0;
		else cnt_reg <= cnt_next;
	end

	// Count holds earlier samples; the current one completes the run
	assign long_enough = level_in && (cnt_reg >= LIMIT - CW'(1));
endmodule

/* File: core/rsq_sequencer.sv */
/*
 System reset sequencer: gathers power-on/brown-out, watchdog, reset pin
 and debugger reset requests, times the power-on delay, records causes.
 Assumes mode and option inputs are synchronous and the debugger and this
 register file sit on aresetn only, so a system reset leaves them intact.
*/
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
// Functional notes
// - Accept POR/brown-out, watchdog, pin and debugger reset requests.
// - Pin reset needs at least four clocks low; shorter pulses ignored.
// - Writing 1 to debugger control bit 0 resets all but the debugger; in stop mode the code holds the bit set and only resets once stop mode ends.
// - In stop mode pin pulses under 12 ns ignored, wider ones reset; the code resets on any low caught at one clock edge, whatever its width.
// - After supply is good, stay in reset until power-on counter expires.
// - Crystal option selects a longer power-on time-out.
// - Leaving reset, the processor is told to fetch its reset vector.
// - Power-on reset sets the power-on status flag.
// - Option bit keeps brown-out detection active or off in stop mode.
// - Watchdog time-out resets when its reset-select option is 1.
// - With reset-select 0, a watchdog time-out raises an interrupt instead.
// - A watchdog reset sets the watchdog status flag.
`timescale 1ns/1ps
module rsq_sequencer
	import rsq_pkg::*;
#(
	parameter int POR_CYCLES = POR_CYCLES_DEF,
	parameter int XTAL_CYCLES = XTAL_CYCLES_DEF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic supply_ok,
	input wire logic stop_mode,
	input wire logic xtal_enable,
	input wire logic brownout_active_in_stop,
	input wire logic watchdog_reset_select,
	input wire logic watchdog_timeout,
	input wire logic reset_pin_n,
	input wire logic debug_pin_n,
	output logic sys_reset_n,
	output logic fetch_vector,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	initial begin
		if (POR_CYCLES < 1 || XTAL_CYCLES < POR_CYCLES) $error("Bad power-on counts");
	end

	logic pin_low_s;
	logic pin_req_norm;
	logic pin_req_stop;
	logic pin_req;
	logic dbgpin_req;
	logic wdt_rst;
	logic wdt_int;
	logic dbg_req;
	logic por_cond;
	logic ext_req;
	logic [31:0] por_limit;

	// Pin first synchronised, then width-checked
	rsq_sync2 u_pin_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(!reset_pin_n),
		.sync_out(pin_low_s)
	);

	rsq_width_filter #(.MIN_CYCLES(PIN_MIN_CYCLES)) u_pin_norm (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(pin_low_s),
		.long_enough(pin_req_norm)
	);

	// No clock edge resolves 12 ns; one sampled cycle is the narrowest catch
	rsq_width_filter #(.MIN_CYCLES(STOP_FILTER_CYCLES)) u_pin_stop (
		.aclk(aclk),
		.aresetn(aresetn),
		.level_in(pin_low_s),
		.long_enough(pin_req_stop)
	);

	// Register state
	logic [7:0] ctrl_reg, ctrl_next;
	logic [STAT_W-1:0] status_reg, status_next;
	logic [STAT_W-1:0] mask_reg, mask_next;
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [7:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;

	// Sequencer state
	rsq_state_t state_reg, state_next;
	logic [31:0] por_cnt_reg, por_cnt_next;
	logic sys_reset_n_reg, sys_reset_n_next;
	logic fetch_reg, fetch_next;

	// Request sources
	always_comb begin
		pin_req = stop_mode ? pin_req_stop : pin_req_norm;
		dbgpin_req = stop_mode && !debug_pin_n;
		dbg_req = ctrl_reg[CTRL_RST_BIT] && !stop_mode;
		wdt_rst = watchdog_timeout && watchdog_reset_select;
		wdt_int = watchdog_timeout && !watchdog_reset_select;
		por_cond = !supply_ok && !(stop_mode && !brownout_active_in_stop);
		ext_req = wdt_rst || pin_req || dbg_req || dbgpin_req;
		por_limit = xtal_enable ? XTAL_CYCLES : POR_CYCLES;
	end

	// Reset sequence: power-on wait, hold until no request remains, run
	always_comb begin
		state_next = state_reg;
		por_cnt_next = por_cnt_reg;
		case (state_reg)
			RSQ_POR_WAIT: begin
				if (por_cond) begin
					por_cnt_next = '0;
				end else if (por_cnt_reg >= por_limit - 32'd1) begin
					state_next = RSQ_HOLD;
					por_cnt_next = '0;
				end else begin
					por_cnt_next = por_cnt_reg + 32'd1;
				end
			end
			RSQ_HOLD: begin
				if (por_cond) state_next = RSQ_POR_WAIT;
				else if (!ext_req) state_next = RSQ_RUN;
			end
			RSQ_RUN: begin
				if (por_cond) state_next = RSQ_POR_WAIT;
				else if (ext_req) state_next = RSQ_HOLD;
			end
			default: state_next = RSQ_POR_WAIT;
		endcase
		// Output registered so release is glitch-free and synchronous
		sys_reset_n_next = (state_next == RSQ_RUN);
		fetch_next = (state_next == RSQ_RUN) && (state_reg != RSQ_RUN);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= RSQ_POR_WAIT;
			por_cnt_reg <= '0;
			sys_reset_n_reg <= 1'b0;
			fetch_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			por_cnt_reg <= por_cnt_next;
			sys_reset_n_reg <= sys_reset_n_next;
			fetch_reg <= fetch_next;
		end
	end

	// Bus slave and registers; writes land once address and data both held
	always_comb begin
		logic do_write;
		logic rd_hit;
		do_write = aw_have_reg && w_have_reg && !bvalid_reg;
		rd_hit = s_axi_arvalid && !rvalid_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		awaddr_next = awaddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			awaddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) bvalid_next = 1'b0;
		if (s_axi_rvalid && s_axi_rready) rvalid_next = 1'b0;
		// Hardware drops the debugger request once the hold is reached
		if (state_reg == RSQ_HOLD) ctrl_next[CTRL_RST_BIT] = 1'b0;
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			case (awaddr_reg & 8'hFC)
				OFS_DBG_CTRL: if (wstrb_reg[0]) ctrl_next = wdata_reg[7:0];
				OFS_MASK: if (wstrb_reg[0]) mask_next = wdata_reg[STAT_W-1:0];
				OFS_STATUS, OFS_STATE: bresp_next = RESP_OKAY;
				default: bresp_next = RESP_SLVERR;
			endcase
		end
		if (rd_hit) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			rdata_next = 32'h0000_0000;
			case (s_axi_araddr & 8'hFC)
				OFS_DBG_CTRL: rdata_next[7:0] = ctrl_reg;
				OFS_STATUS: begin
					rdata_next[STAT_W-1:0] = status_reg;
					status_next = '0; // read clears
				end
				OFS_MASK: rdata_next[STAT_W-1:0] = mask_reg;
				OFS_STATE: rdata_next[2:0] = {sys_reset_n_reg, state_reg};
				default: rresp_next = RESP_SLVERR;
			endcase
		end
		// Causes set after the read clear so a same-cycle event survives
		if (state_reg == RSQ_POR_WAIT && state_next == RSQ_HOLD) status_next[ST_POR_BIT] = 1'b1;
		if (wdt_rst) status_next[ST_WDT_BIT] = 1'b1;
		if (pin_req) status_next[ST_PIN_BIT] = 1'b1;
		if (dbg_req || dbgpin_req) status_next[ST_DBG_BIT] = 1'b1;
		if (wdt_int) status_next[ST_WIRQ_BIT] = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			ctrl_reg <= CTRL_RESET;
			mask_reg <= MASK_RESET;
			status_reg <= STATUS_RESET;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			awaddr_reg <= awaddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
		end
	end

	// Outputs
	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready = !w_have_reg && !bvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign sys_reset_n = sys_reset_n_reg;
	assign fetch_vector = fetch_reg;
	assign irq = |(status_reg & mask_reg);

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_pin_width;
		(!stop_mode && pin_req) |-> (pin_low_s && $past(pin_low_s, 1)
			&& $past(pin_low_s, 2) && $past(pin_low_s, 3));
	endproperty
	a_pin_width: assert property (p_pin_width) else $error("pin reset under four clocks");

	property p_por_hold;
		(state_reg == RSQ_POR_WAIT && por_cond) |=> (!sys_reset_n && por_cnt_reg == 32'd0);
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("reset released during power fail");

	property p_release_clean;
		$rose(sys_reset_n) |-> ($past(state_reg) == RSQ_HOLD && !$past(ext_req) && fetch_vector);
	endproperty
	a_release_clean: assert property (p_release_clean) else $error("release not after hold");

	property p_fetch;
		fetch_vector |-> sys_reset_n ##1 !fetch_vector;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch pulse wrong");

	property p_por_flag;
		(state_reg == RSQ_POR_WAIT && state_next == RSQ_HOLD) |=> status_reg[ST_POR_BIT];
	endproperty
	a_por_flag: assert property (p_por_flag) else $error("power-on flag not set");

	property p_wdt_reset;
		(watchdog_timeout && watchdog_reset_select) |=> (!sys_reset_n ##0 status_reg[ST_WDT_BIT]);
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");

	property p_wdt_flag;
		wdt_rst |=> status_reg[ST_WDT_BIT];
	endproperty
	a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

	property p_wdt_irq;
		(watchdog_timeout && !watchdog_reset_select && state_reg == RSQ_RUN && !por_cond
			&& !pin_req && !dbg_req && !dbgpin_req) |=> (sys_reset_n && status_reg[ST_WIRQ_BIT]);
	endproperty
	a_wdt_irq: assert property (p_wdt_irq) else $error("watchdog interrupt path wrong");

	property p_dbg_reset;
		(ctrl_reg[CTRL_RST_BIT] && !stop_mode && state_reg == RSQ_RUN && !por_cond)
			|=> !sys_reset_n;
	endproperty
	a_dbg_reset: assert property (p_dbg_reset) else $error("debugger reset missing");

	property p_stop_pin;
		(stop_mode && pin_low_s && state_reg == RSQ_RUN) |-> ##[1:2] !sys_reset_n;
	endproperty
	a_stop_pin: assert property (p_stop_pin) else $error("stop pin reset missing");

	property p_bo_stop;
		(state_reg == RSQ_RUN && stop_mode && !brownout_active_in_stop && !ext_req)
			|=> state_reg == RSQ_RUN;
	endproperty
	a_bo_stop: assert property (p_bo_stop) else $error("brown-out acted in stop");

	property p_xtal_long;
		(state_reg == RSQ_POR_WAIT && xtal_enable && por_cnt_reg < 32'(POR_CYCLES))
			|=> state_reg != RSQ_HOLD || $past(por_cnt_reg) >= 32'(XTAL_CYCLES - 1);
	endproperty
	a_xtal_long: assert property (p_xtal_long) else $error("short time-out with crystal");
endmodule

/* File: dv/rsq_board_pin.sv */
/*
 Board-side model of the logic that drives the external reset pin.
 Assumes one system clock; the pin has a pull-up, so it idles high.
*/
`timescale 1ns/1ps
module rsq_board_pin (
	input wire logic aclk,
	output logic reset_pin_n
);
	// Pull-up holds the pin high between pulses
	initial begin
		reset_pin_n = 1'b1;
	end

	// Low pulse of a whole number of clocks, launched after a rising edge
	task automatic pulse(input int cycles);
		@(posedge aclk);
		reset_pin_n <= 1'b0;
		repeat (cycles) @(posedge aclk);
		reset_pin_n <= 1'b1;
	endtask
endmodule

/* File: dv/system_reset_sequencer_tb_top.sv */
/*
 Self-checking bench for the reset sequencer: AXI4-Lite tasks and reset scenarios.
 Assumes the DUT is built with short power-on counts of 8 and 16 cycles.
*/
`timescale 1ns/1ps
module system_reset_sequencer_tb_top;
	import rsq_pkg::*;
	localparam int POR_SIM = 8;
	localparam int XTAL_SIM = 16;
	logic aclk, aresetn, supply_ok, stop_mode, xtal_enable, brownout_active_in_stop;
	logic watchdog_reset_select, watchdog_timeout, reset_pin_n, debug_pin_n;
	logic sys_reset_n, fetch_vector, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, r;
	logic low_seen;
	int bad_count, n_checks, cyc, n;

	rsq_board_pin board (.aclk(aclk), .reset_pin_n(reset_pin_n));

	rsq_sequencer #(.POR_CYCLES(POR_SIM), .XTAL_CYCLES(XTAL_SIM)) DUT (
		.aclk(aclk), .aresetn(aresetn), .supply_ok(supply_ok), .stop_mode(stop_mode),
		.xtal_enable(xtal_enable), .brownout_active_in_stop(brownout_active_in_stop),
		.watchdog_reset_select(watchdog_reset_select), .watchdog_timeout(watchdog_timeout),
		.reset_pin_n(reset_pin_n), .debug_pin_n(debug_pin_n), .sys_reset_n(sys_reset_n),
		.fetch_vector(fetch_vector), .irq(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready)
	);

	// 20 MHz clock
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Sticky record of any system reset, sampled mid-cycle
	always @(negedge aclk) begin
		if (sys_reset_n === 1'b0) low_seen = 1'b1;
	end

	// Hang guard far above the expected run length
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Both write channels offered together, each released when taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		bit aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!(arvalid && arready));
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// Cycles until sys_reset_n reaches a level, bounded
	task automatic wait_level(input logic v, output int k);
		k = 0;
		while (sys_reset_n !== v && k < 200) begin
			@(negedge aclk);
			k++;
		end
	endtask

	task automatic settle(input logic exp);
		repeat (30) @(negedge aclk);
		chk(low_seen, exp);
		chk(sys_reset_n, 1'b1);
	endtask

	task automatic rd_status(input logic [31:0] exp);
		axi_read(OFS_STATUS, d, r);
		chk(d, exp);
	endtask

	task automatic wdog_tick();
		@(posedge aclk);
		watchdog_timeout <= 1'b1;
		@(posedge aclk);
		watchdog_timeout <= 1'b0;
	endtask

	initial begin
		{aresetn, stop_mode, xtal_enable, brownout_active_in_stop, watchdog_timeout} = '0;
		{awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
		{supply_ok, debug_pin_n, watchdog_reset_select} = 3'b111;
		{bad_count, n_checks, cyc} = '0;
		low_seen = 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		// Power-on wait, vector fetch, power-on cause
		wait_level(1'b1, n);
		chk(32'(n >= POR_SIM && n < 200), 1);
		chk(fetch_vector, 1'b1);
		@(negedge aclk);
		chk(fetch_vector, 1'b0);
		rd_status(32'h01);
		rd_status(32'h00);
		axi_read(OFS_STATE, d, r);
		chk(d, 32'h6);
		axi_read(8'h10, d, r);
		chk(r, RESP_SLVERR);
		chk(d, 32'h0);
		axi_write(OFS_MASK, 32'h1F, r);
		chk(r, RESP_OKAY);
		axi_read(OFS_MASK, d, r);
		chk(d, 32'h1F);
		chk(r, RESP_OKAY);
		// Pin pulses below and above the normal-mode width
		low_seen = 1'b0;
		board.pulse(PIN_MIN_CYCLES - 1);
		settle(1'b0);
		board.pulse(PIN_MIN_CYCLES + 4);
		settle(1'b1);
		chk(irq, 1'b1);
		rd_status(32'h04);
		chk(irq, 1'b0);
		// Watchdog as reset, then as interrupt event
		low_seen = 1'b0;
		wdog_tick();
		settle(1'b1);
		rd_status(32'h02);
		watchdog_reset_select <= 1'b0;
		low_seen = 1'b0;
		wdog_tick();
		settle(1'b0);
		chk(irq, 1'b1);
		rd_status(32'h10);
		// Debugger control bit resets the system and self-clears
		low_seen = 1'b0;
		axi_write(OFS_DBG_CTRL, 32'h1, r);
		chk(r, RESP_OKAY);
		settle(1'b1);
		rd_status(32'h08);
		axi_read(OFS_DBG_CTRL, d, r);
		chk(d, 32'h0);
		// Stop mode: debug pin low, short pin pulse, ignored supply drop
		stop_mode <= 1'b1;
		low_seen = 1'b0;
		@(posedge aclk);
		debug_pin_n <= 1'b0;
		repeat (3) @(posedge aclk);
		debug_pin_n <= 1'b1;
		settle(1'b1);
		rd_status(32'h08);
		low_seen = 1'b0;
		board.pulse(2);
		settle(1'b1);
		rd_status(32'h04);
		low_seen = 1'b0;
		@(posedge aclk);
		supply_ok <= 1'b0;
		repeat (5) @(posedge aclk);
		supply_ok <= 1'b1;
		settle(1'b0);
		// Brown-out in normal mode with the crystal's longer count
		@(posedge aclk);
		stop_mode <= 1'b0;
		xtal_enable <= 1'b1;
		supply_ok <= 1'b0;
		repeat (5) @(posedge aclk);
		supply_ok <= 1'b1;
		wait_level(1'b0, n);
		wait_level(1'b1, n);
		chk(32'(n >= XTAL_SIM && n < 200), 1);
		rd_status(32'h01);
		wrap_up();
	end
endmodule
